// ===== src/apm_defs.vh
// Purpose: shared constants for the task-file command block
// Assumes: byte-wide task registers, 16-bit data register
// Notes:   definitions only
`ifndef APM_DEFS_VH
`define APM_DEFS_VH
// register offsets
`define APM_OFS_DATA       4'h0
`define APM_OFS_FEATURE    4'h1
`define APM_OFS_SECCNT     4'h2
`define APM_OFS_SECNUM     4'h3
`define APM_OFS_CYLLO      4'h4
`define APM_OFS_CYLHI      4'h5
`define APM_OFS_DRVHEAD    4'h6
`define APM_OFS_COMMAND    4'h7
`define APM_OFS_CONFIG     4'h8
`define APM_OFS_STATE      4'h9
// command codes
`define APM_CMD_SET_MULT   8'hC6
`define APM_CMD_SLEEP_A    8'h99
`define APM_CMD_SLEEP_B    8'hE6
`define APM_CMD_STBY_A     8'h96
`define APM_CMD_STBY_B     8'hE2
`define APM_CMD_STBYI_A    8'h94
`define APM_CMD_STBYI_B    8'hE0
`define APM_CMD_TRANSLATE  8'h87
`define APM_CMD_WEAR       8'hF5
`define APM_CMD_WR_BUF     8'hE8
`define APM_CMD_WR_DMA     8'hCA
`define APM_CMD_WR_MULT    8'hC5
// status and error bits
`define APM_ST_BSY         7
`define APM_ST_DRDY        6
`define APM_ST_DRQ         3
`define APM_ST_ERR         0
`define APM_ER_ABRT        2
`define APM_ER_UNC         6
// config register fields
`define APM_CFG_8BIT       0
`define APM_CFG_RETAIN     1
`define APM_CFG_SECURITY   2
// translate buffer byte values
`define APM_ERASED_BYTE    8'hFF
`define APM_NOT_ERASED     8'h00
// sector geometry, set-multiple limit and idle timer
`define APM_WORDS_PER_SEC  256
`define APM_MAX_SECTORS    256
`define APM_SLEEP_US       5000
`define APM_CLK_MHZ        25
`define APM_MULT_MAX       16
`endif

// ===== src/apm_sector_buf.v
// Purpose: 512-byte sector buffer held as 256 16-bit words
// Assumes: one write port, combinational read
// Notes:   read data is registered by the caller
`timescale 1ns/1ns
module apm_sector_buf #(
  parameter WORDS = 256,
  parameter AW    = 8
) (
  input  wire          i_clock,
  input  wire          i_we,
  input  wire [AW-1:0] i_addr,
  input  wire [15:0]   i_wdata,
  output wire [15:0]   o_rdata
);
  reg [15:0] mem [0:WORDS-1];

  always @(posedge i_clock)
  begin
    if (i_we)
    begin
      mem[i_addr] <= i_wdata;
    end
  end

  assign o_rdata = mem[i_addr];
endmodule

// ===== src/apm_idle_timer.v
// Purpose: idle timer that requests sleep after a quiet period
// Assumes: i_kick restarts the count; counting only while i_run
// Notes:   o_expire is a one-cycle pulse
`timescale 1ns/1ns
module apm_idle_timer #(
  parameter CYCLES = 125000,
  parameter CW     = 17
) (
  input  wire i_clock,
  input  wire i_reset,
  input  wire i_run,
  input  wire i_kick,
  output reg  o_expire
);
  reg [CW-1:0] count_ff;

  always @(posedge i_clock)
  begin
    if (i_reset || i_kick || !i_run)
    begin
      count_ff <= {CW{1'b0}};
      o_expire <= 1'b0;
    end
    else if (count_ff == CYCLES[CW-1:0] - 1'b1)
    begin
      count_ff <= {CW{1'b0}};
      o_expire <= 1'b1;
    end
    else
    begin
      count_ff <= count_ff + 1'b1;
      o_expire <= 1'b0;
    end
  end
endmodule

// ===== src/apm_cmd_engine.v
// Purpose: executes set-multiple, sleep, standby, translate, wear level,
//          write buffer and write DMA commands of the task file
// Assumes: host writes registers over a plain strobe port, data port 16 bit
// Notes:   flash media is outside; it reports erase state, hot count, errors
//
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/1ns
`include "apm_defs.vh"
module apm_cmd_engine #(
  parameter IDLE_CYCLES = `APM_SLEEP_US * `APM_CLK_MHZ,
  parameter MULT_MAX    = `APM_MULT_MAX
) (
  input  wire        i_clock,
  input  wire        i_reset,
  input  wire        i_soft_reset,
  input  wire [3:0]  i_addr,
  input  wire [15:0] i_wdata,
  input  wire        i_wr,
  input  wire        i_rd,
  input  wire        i_dmack,
  input  wire        i_dma_wr,
  input  wire        i_media_erased,
  input  wire [23:0] i_media_hot_count,
  input  wire        i_media_error,
  output reg  [15:0] o_rdata,
  output reg         o_intrq,
  output reg         o_dmareq,
  output reg         o_sleep,
  output reg         o_busy
);
  localparam ST_IDLE  = 3'd0;
  localparam ST_EVAL  = 3'd1;
  localparam ST_PIOIN = 3'd2;
  localparam ST_PIOWR = 3'd3;
  localparam ST_DMA   = 3'd4;

  reg [2:0]  state_ff;
  reg [7:0]  sector_count_param_ff;
  reg [7:0]  sector_number_addr_ff;
  reg [7:0]  cylinder_low_addr_ff;
  reg [7:0]  cylinder_high_addr_ff;
  reg [7:0]  drive_head_select_ff;
  reg [7:0]  command_code_ff;
  reg [7:0]  error_ff;
  reg        err_ff;
  reg        drq_ff;
  reg [2:0]  config_ff;
  reg        mult_en_ff;
  reg [7:0]  mult_count_ff;
  reg        frozen_ff;
  reg [7:0]  word_ptr_ff;
  reg [8:0]  remain_ff;
  reg [15:0] xlate_word;
  reg [7:0]  status_byte;
  wire [15:0] buf_rdata;
  wire        idle_expire;
  wire        cmd_wr;
  wire        data_wr;
  wire        data_rd;
  wire        dma_word;
  wire        buf_we;
  wire [27:0] lba;
  wire [27:0] lba_next;

  assign cmd_wr   = i_wr && (i_addr == `APM_OFS_COMMAND);
  assign data_wr  = i_wr && (i_addr == `APM_OFS_DATA) && (state_ff == ST_PIOWR);
  assign data_rd  = i_rd && (i_addr == `APM_OFS_DATA) && (state_ff == ST_PIOIN);
  assign dma_word = (state_ff == ST_DMA) && o_dmareq && i_dmack && i_dma_wr;
  assign buf_we   = data_wr || dma_word;
  assign lba      = {drive_head_select_ff[3:0], cylinder_high_addr_ff,
                     cylinder_low_addr_ff, sector_number_addr_ff};
  assign lba_next = lba + 28'h000_0001;

  apm_sector_buf #(
    .WORDS (`APM_WORDS_PER_SEC),
    .AW    (8)
  ) u_buf (
    .i_clock (i_clock),
    .i_we    (buf_we),
    .i_addr  (word_ptr_ff),
    .i_wdata (i_wdata),
    .o_rdata (buf_rdata)
  );

  // the timer only runs while the block is idle and awake
  apm_idle_timer #(
    .CYCLES (IDLE_CYCLES),
    .CW     (24)
  ) u_timer (
    .i_clock  (i_clock),
    .i_reset  (i_reset),
    .i_run    ((state_ff == ST_IDLE) && !o_sleep),
    .i_kick   (i_wr || i_rd),
    .o_expire (idle_expire)
  );

  function [7:0] xlate_byte;
    input [8:0] idx;
    begin
      case (idx)
        9'h000:  xlate_byte = cylinder_high_addr_ff;
        9'h001:  xlate_byte = cylinder_low_addr_ff;
        9'h002:  xlate_byte = {4'h0, drive_head_select_ff[3:0]};
        9'h003:  xlate_byte = sector_number_addr_ff;
        9'h004:  xlate_byte = lba[23:16];
        9'h005:  xlate_byte = lba[15:8];
        9'h006:  xlate_byte = lba[7:0];
        9'h013:  xlate_byte = i_media_erased ? `APM_ERASED_BYTE
                                             : `APM_NOT_ERASED;
        9'h018:  xlate_byte = i_media_hot_count[23:16];
        9'h019:  xlate_byte = i_media_hot_count[15:8];
        9'h01A:  xlate_byte = i_media_hot_count[7:0];
        default: xlate_byte = 8'h00;
      endcase
    end
  endfunction

  // low byte of each word carries the even byte of the buffer
  always @*
  begin
    xlate_word = {xlate_byte({word_ptr_ff, 1'b1}), xlate_byte({word_ptr_ff, 1'b0})};
    status_byte = 8'h00;
    status_byte[`APM_ST_BSY]  = o_busy;
    status_byte[`APM_ST_DRDY] = !o_busy;
    status_byte[`APM_ST_DRQ]  = drq_ff;
    status_byte[`APM_ST_ERR]  = err_ff;
  end

  // register reads: data one cycle after the strobe
  always @(posedge i_clock)
  begin
    if (i_reset)
    begin
      o_rdata <= 16'h0000;
    end
    else if (i_rd)
    begin
      case (i_addr)
        `APM_OFS_DATA:    o_rdata <= data_rd ? xlate_word : buf_rdata;
        `APM_OFS_FEATURE: o_rdata <= {8'h00, error_ff};
        `APM_OFS_SECCNT:  o_rdata <= {8'h00, sector_count_param_ff};
        `APM_OFS_SECNUM:  o_rdata <= {8'h00, sector_number_addr_ff};
        `APM_OFS_CYLLO:   o_rdata <= {8'h00, cylinder_low_addr_ff};
        `APM_OFS_CYLHI:   o_rdata <= {8'h00, cylinder_high_addr_ff};
        `APM_OFS_DRVHEAD: o_rdata <= {8'h00, drive_head_select_ff};
        `APM_OFS_COMMAND: o_rdata <= {8'h00, status_byte};
        `APM_OFS_CONFIG:  o_rdata <= {13'h0000, config_ff};
        `APM_OFS_STATE:   o_rdata <= {mult_count_ff, 4'h0, frozen_ff, mult_en_ff,
                                      o_sleep, drq_ff};
        default:          o_rdata <= 16'h0000;
      endcase
    end
    else
    begin
      o_rdata <= 16'h0000;
    end
  end

  // command engine and task file
  always @(posedge i_clock)
  begin
    if (i_reset)
    begin
      state_ff              <= ST_IDLE;
      sector_count_param_ff <= 8'h01;
      sector_number_addr_ff <= 8'h01;
      cylinder_low_addr_ff  <= 8'h00;
      cylinder_high_addr_ff <= 8'h00;
      drive_head_select_ff  <= 8'h00;
      command_code_ff       <= 8'h00;
      error_ff              <= 8'h00;
      err_ff                <= 1'b0;
      drq_ff                <= 1'b0;
      config_ff             <= 3'b000;
      mult_en_ff            <= 1'b0;
      mult_count_ff         <= 8'h00;
      frozen_ff             <= 1'b0;
      word_ptr_ff           <= 8'h00;
      remain_ff             <= 9'h000;
      o_intrq               <= 1'b0;
      o_dmareq              <= 1'b0;
      o_sleep               <= 1'b0;
      o_busy                <= 1'b0;
    end
    else if (i_soft_reset)
    begin
      // soft reset aborts any command; the multiple setting survives only if retained
      state_ff    <= ST_IDLE;
      drq_ff      <= 1'b0;
      err_ff      <= 1'b0;
      error_ff    <= 8'h00;
      o_intrq     <= 1'b0;
      o_dmareq    <= 1'b0;
      o_busy      <= 1'b0;
      o_sleep     <= 1'b0;
      word_ptr_ff <= 8'h00;
      if (!config_ff[`APM_CFG_RETAIN])
      begin
        mult_en_ff    <= 1'b0;
        mult_count_ff <= 8'h00;
      end
    end
    else
    begin
      // reading status acknowledges the interrupt
      if (i_rd && (i_addr == `APM_OFS_COMMAND))
      begin
        o_intrq <= 1'b0;
      end
      if (idle_expire)
      begin
        o_sleep <= 1'b1;
      end
      // task registers are writable only while the block is idle
      if (i_wr && (state_ff == ST_IDLE))
      begin
        case (i_addr)
          // feature writes are accepted and dropped: no command here uses them
          `APM_OFS_SECCNT:  sector_count_param_ff <= i_wdata[7:0];
          `APM_OFS_SECNUM:  sector_number_addr_ff <= i_wdata[7:0];
          `APM_OFS_CYLLO:   cylinder_low_addr_ff  <= i_wdata[7:0];
          `APM_OFS_CYLHI:   cylinder_high_addr_ff <= i_wdata[7:0];
          `APM_OFS_DRVHEAD: drive_head_select_ff  <= i_wdata[7:0];
          `APM_OFS_CONFIG:  config_ff             <= i_wdata[2:0];
          default:          ;
        endcase
      end
      case (state_ff)
        ST_IDLE:
        begin
          if (cmd_wr)
          begin
            command_code_ff <= i_wdata[7:0];
            o_sleep         <= 1'b0;
            o_busy          <= 1'b1;
            o_intrq         <= 1'b0;
            err_ff          <= 1'b0;
            error_ff        <= 8'h00;
            word_ptr_ff     <= 8'h00;
            state_ff        <= ST_EVAL;
          end
        end
        ST_EVAL:
        begin
          // one busy cycle, then act; address and feature registers unused here
          state_ff <= ST_IDLE;
          o_busy   <= 1'b0;
          case (command_code_ff)
            `APM_CMD_SET_MULT:
            begin
              o_intrq <= 1'b1;
              if (sector_count_param_ff == 8'h00)
              begin
                mult_en_ff    <= 1'b0;
                mult_count_ff <= 8'h00;
              end
              else if (sector_count_param_ff <= MULT_MAX[7:0])
              begin
                mult_en_ff    <= 1'b1;
                mult_count_ff <= sector_count_param_ff;
              end
              else
              begin
                mult_en_ff            <= 1'b0;
                mult_count_ff         <= 8'h00;
                err_ff                <= 1'b1;
                error_ff[`APM_ER_ABRT] <= 1'b1;
              end
            end
            `APM_CMD_SLEEP_A, `APM_CMD_SLEEP_B,
            `APM_CMD_STBY_A, `APM_CMD_STBY_B,
            `APM_CMD_STBYI_A, `APM_CMD_STBYI_B:
            begin
              o_sleep <= 1'b1;
              o_intrq <= 1'b1;
            end
            `APM_CMD_TRANSLATE:
            begin
              drq_ff   <= 1'b1;
              o_intrq  <= 1'b1;
              state_ff <= ST_PIOIN;
            end
            `APM_CMD_WEAR:
            begin
              sector_count_param_ff <= 8'h00;
              if (config_ff[`APM_CFG_SECURITY])
              begin
                frozen_ff <= 1'b1;
              end
              o_intrq <= 1'b1;
            end
            `APM_CMD_WR_BUF:
            begin
              // same opening as a sector write: DRQ without interrupt
              drq_ff   <= 1'b1;
              state_ff <= ST_PIOWR;
            end
            `APM_CMD_WR_DMA:
            begin
              if (config_ff[`APM_CFG_8BIT])
              begin
                err_ff                 <= 1'b1;
                error_ff[`APM_ER_ABRT] <= 1'b1;
                o_intrq                <= 1'b1;
              end
              else
              begin
                remain_ff <= (sector_count_param_ff == 8'h00) ?
                             9'h100 : {1'b0, sector_count_param_ff};
                drq_ff    <= 1'b1;
                o_dmareq  <= 1'b1;
                state_ff  <= ST_DMA;
              end
            end
            `APM_CMD_WR_MULT:
            begin
              if (!mult_en_ff)
              begin
                err_ff                 <= 1'b1;
                error_ff[`APM_ER_ABRT] <= 1'b1;
              end
              o_intrq <= 1'b1;
            end
            default:
            begin
              err_ff                 <= 1'b1;
              error_ff[`APM_ER_ABRT] <= 1'b1;
              o_intrq                <= 1'b1;
            end
          endcase
        end
        ST_PIOIN:
        begin
          if (data_rd)
          begin
            word_ptr_ff <= word_ptr_ff + 8'h01;
            if (word_ptr_ff == 8'hFF)
            begin
              drq_ff   <= 1'b0;
              state_ff <= ST_IDLE;
            end
          end
        end
        ST_PIOWR:
        begin
          if (data_wr)
          begin
            word_ptr_ff <= word_ptr_ff + 8'h01;
            if (word_ptr_ff == 8'hFF)
            begin
              drq_ff   <= 1'b0;
              o_intrq  <= 1'b1;
              state_ff <= ST_IDLE;
            end
          end
        end
        ST_DMA:
        begin
          // media error stops at the failing sector and leaves its address
          if (i_media_error)
          begin
            o_dmareq               <= 1'b0;
            drq_ff                 <= 1'b0;
            err_ff                 <= 1'b1;
            error_ff[`APM_ER_UNC]  <= 1'b1;
            sector_count_param_ff  <= remain_ff[7:0];
            o_intrq                <= 1'b1;
            state_ff               <= ST_IDLE;
          end
          else if (dma_word)
          begin
            word_ptr_ff <= word_ptr_ff + 8'h01;
            if (word_ptr_ff == 8'hFF)
            begin
              if (remain_ff == 9'h001)
              begin
                o_dmareq              <= 1'b0;
                drq_ff                <= 1'b0;
                sector_count_param_ff <= 8'h00;
                o_intrq               <= 1'b1;
                state_ff              <= ST_IDLE;
              end
              else
              begin
                remain_ff             <= remain_ff - 9'h001;
                sector_number_addr_ff <= lba_next[7:0];
                cylinder_low_addr_ff  <= lba_next[15:8];
                cylinder_high_addr_ff <= lba_next[23:16];
                drive_head_select_ff  <= {drive_head_select_ff[7:4], lba_next[27:24]};
              end
            end
          end
        end
        default:
        begin
          state_ff <= ST_IDLE;
        end
      endcase
    end
  end
endmodule

// ===== tb/apm_dma_host.sv
// Purpose: host side of the DMA write handshake
// Assumes: one word offered per cycle while the request stands; only on random cycles with i_slow
// Notes:   o_words counts words the engine really took
`timescale 1ns/1ns
module apm_dma_host (
  input  wire        i_clock,
  input  wire        i_reset,
  input  wire        i_en,
  input  wire        i_slow,
  input  wire        i_dmareq,
  output reg         o_dmack,
  output reg         o_dma_wr,
  output reg  [15:0] o_data,
  output reg  [31:0] o_words
);
  always @(posedge i_clock)
  begin
    if (i_reset)
    begin
      o_dmack  <= 1'b0;
      o_dma_wr <= 1'b0;
      o_data   <= 16'h0000;
      o_words  <= 32'h0000_0000;
    end
    else
    begin
      if (o_dmack && o_dma_wr && i_dmareq)
        o_words <= o_words + 32'h0000_0001;
      if (i_en && i_dmareq)
      begin
        o_dmack  <= 1'b1;
        o_dma_wr <= i_slow ? 1'($urandom) : 1'b1;
        o_data   <= 16'($urandom);
      end
      else
      begin
        // released bus alternates between the stale word and its complement
        o_dmack  <= 1'b0;
        o_dma_wr <= 1'b0;
        o_data   <= ~o_data;
      end
    end
  end
endmodule

// ===== tb/apm_cmd_engine_assertions.sv
// Purpose: port-level timing checks of the command engine
// Assumes: commands are written only while the engine is idle
// Notes:   quiet_ff bounds how early the idle timer may fire
`timescale 1ns/1ns
module apm_cmd_engine_assertions #(
  parameter IDLE_CYCLES = 125000
) (
  input wire        i_clock,
  input wire        i_reset,
  input wire        i_soft_reset,
  input wire [3:0]  i_addr,
  input wire [15:0] i_wdata,
  input wire        i_wr,
  input wire        i_rd,
  input wire        i_dma_wr,
  input wire [15:0] o_rdata,
  input wire        o_intrq,
  input wire        o_dmareq,
  input wire        o_sleep,
  input wire        o_busy
);
  wire [7:0]  c      = i_wdata[7:0];
  wire        cmd_wr = i_wr && (i_addr == 4'h7) && !o_busy && !o_dmareq;
  wire        slp    = (c == 8'h99) || (c == 8'hE6) || (c == 8'h96) || (c == 8'hE2)
                       || (c == 8'h94) || (c == 8'hE0);
  wire        noisy  = i_wr || i_rd || i_dma_wr || o_busy || o_dmareq;
  reg  [31:0] quiet_ff;
  wire [31:0] nxt_quiet = noisy ? 32'h0000_0000 : quiet_ff + 32'h0000_0001;
  always @(posedge i_clock)
  begin
    quiet_ff <= i_reset ? 32'h0000_0000 : nxt_quiet;
  end
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_reset || i_soft_reset);
  property p_busy_one; o_busy |=> !o_busy; endproperty
  a_busy_one: assert property (p_busy_one) else $error("busy too long");
  property p_busy_cause; $rose(o_busy) |-> $past(i_wr) && $past(i_addr) == 4'h7; endproperty
  a_busy_cause: assert property (p_busy_cause) else $error("busy without command");
  property p_sleep; cmd_wr && slp |=> o_busy ##1 (o_sleep && o_intrq); endproperty
  a_sleep: assert property (p_sleep) else $error("sleep sequence wrong");
  property p_wake; o_sleep && cmd_wr && !slp |-> ##[1:2] !o_sleep; endproperty
  a_wake: assert property (p_wake) else $error("no wake on command");
  property p_timer;
    $rose(o_sleep) |-> $past(cmd_wr && slp, 2) || (quiet_ff >= IDLE_CYCLES - 2);
  endproperty
  a_timer: assert property (p_timer) else $error("sleep too early");
  property p_dma_start; $rose(o_dmareq) |-> $past(o_busy); endproperty
  a_dma_start: assert property (p_dma_start) else $error("dma request without busy");
  property p_dma_busy; o_dmareq |-> !o_busy; endproperty
  a_dma_busy: assert property (p_dma_busy) else $error("busy during dma");
  property p_dma_end;
    $fell(o_dmareq) && !$past(i_soft_reset) && !$past(i_reset) |-> o_intrq;
  endproperty
  a_dma_end: assert property (p_dma_end) else $error("dma end without interrupt");
  property p_dma_quiet; o_dmareq && $past(o_dmareq) |-> !$rose(o_intrq); endproperty
  a_dma_quiet: assert property (p_dma_quiet) else $error("interrupt mid dma");
  property p_rdata; !$past(i_rd) |-> o_rdata == 16'h0000; endproperty
  a_rdata: assert property (p_rdata) else $error("read data outside slot");
endmodule
bind apm_cmd_engine apm_cmd_engine_assertions #(.IDLE_CYCLES(IDLE_CYCLES)) u_chk (
  .i_clock(i_clock), .i_reset(i_reset), .i_soft_reset(i_soft_reset), .i_addr(i_addr),
  .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .i_dma_wr(i_dma_wr), .o_rdata(o_rdata),
  .o_intrq(o_intrq), .o_dmareq(o_dmareq), .o_sleep(o_sleep), .o_busy(o_busy));

// ===== tb/apm_cmd_engine_tb_top.sv
// Purpose: self-checking bench of the command engine
// Assumes: short idle timer, DMA host model beside the register master
// Notes:   expectations come from the driven values only
`timescale 1ns/1ns
`include "apm_defs.vh"
module apm_cmd_engine_tb_top;
  localparam        IDLE = 50;
  localparam [47:0] SLP = {`APM_CMD_SLEEP_A, `APM_CMD_SLEEP_B, `APM_CMD_STBY_A,
                           `APM_CMD_STBY_B, `APM_CMD_STBYI_A, `APM_CMD_STBYI_B};
  reg         i_clock = 0, i_reset = 1, i_soft_reset = 0, i_wr = 0, i_rd = 0;
  reg         host_en = 0, slow = 0, i_media_erased = 0, i_media_error = 0;
  reg  [3:0]  i_addr = 0;
  reg  [15:0] bus_wd = 0, d;
  reg  [23:0] i_media_hot_count = 0;
  reg  [7:0]  sn, cl, ch, dh;
  reg  [27:0] lba;
  reg  [15:0] wq [$];
  wire [15:0] o_rdata, dma_wd, i_wdata;
  wire        o_intrq, o_dmareq, o_sleep, o_busy, i_dmack, i_dma_wr;
  wire [31:0] words;
  integer     err_total = 0, cmp_count = 0, i, k, n, base, seed_v;
  assign i_wdata = i_dmack ? dma_wd : bus_wd;
  apm_cmd_engine #(.IDLE_CYCLES(IDLE)) apm_cmd_engine_i (
    .i_clock(i_clock), .i_reset(i_reset), .i_soft_reset(i_soft_reset), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .i_dmack(i_dmack), .i_dma_wr(i_dma_wr),
    .i_media_erased(i_media_erased), .i_media_hot_count(i_media_hot_count),
    .i_media_error(i_media_error), .o_rdata(o_rdata), .o_intrq(o_intrq),
    .o_dmareq(o_dmareq), .o_sleep(o_sleep), .o_busy(o_busy));
  apm_dma_host apm_dma_host_i (
    .i_clock(i_clock), .i_reset(i_reset), .i_en(host_en), .i_slow(slow),
    .i_dmareq(o_dmareq), .o_dmack(i_dmack), .o_dma_wr(i_dma_wr), .o_data(dma_wd),
    .o_words(words));
  function [7:0] tbyte(input integer j);
    case (j)
      0: tbyte = ch;
      1: tbyte = cl;
      2: tbyte = {4'h0, dh[3:0]};
      3: tbyte = sn;
      4: tbyte = ch;
      5: tbyte = cl;
      6: tbyte = sn;
      19: tbyte = i_media_erased ? `APM_ERASED_BYTE : `APM_NOT_ERASED;
      24: tbyte = i_media_hot_count[23:16];
      25: tbyte = i_media_hot_count[15:8];
      26: tbyte = i_media_hot_count[7:0];
      default: tbyte = 8'h00;
    endcase
  endfunction
  task chk(input [15:0] seen, input [15:0] exp);
  begin
    cmp_count = cmp_count + 1;
    if (seen !== exp)
    begin
      err_total = err_total + 1;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  end
  endtask
  task wr(input [3:0] a, input [15:0] v);
  begin
    @(posedge i_clock);
    i_addr <= a;
    bus_wd <= v;
    i_wr <= 1'b1;
    @(posedge i_clock);
    i_wr <= 1'b0;
    #1;
  end
  endtask
  task rd(input [3:0] a, output [15:0] v);
  begin
    @(posedge i_clock);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clock);
    i_rd <= 1'b0;
    #1;
    v = o_rdata;
  end
  endtask
  task cmd(input [7:0] c);
  begin
    wr(4'h7, {8'h00, c});
    chk(o_busy, 1);
    @(posedge i_clock);
    #1;
  end
  endtask
  task sreset;
  begin
    @(posedge i_clock);
    i_soft_reset <= 1'b1;
    @(posedge i_clock);
    i_soft_reset <= 1'b0;
    #1;
  end
  endtask
  task wrap_up;
  begin
    if (err_total == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  end
  endtask
  initial forever #20 i_clock = ~i_clock;
  initial
  begin
    #(40 * 90000);
    err_total = err_total + 1;
    wrap_up;
  end
  initial
  begin
    seed_v = $urandom(32'he2bcfd4b);
    repeat (12) @(posedge i_clock);
    i_reset <= 1'b0;
    rd(4'h9, d);
    chk(d, 0);
    for (k = 0; k < 4; k = k + 1)
    begin
      n = (k == 0) ? 1 : (k == 1) ? `APM_MULT_MAX : (k == 2) ? `APM_MULT_MAX + 1 : 0;
      // address and feature contents must not matter here
      wr(4'h1, 16'($urandom));
      wr(4'h4, 16'($urandom));
      wr(4'h2, n[15:0]);
      cmd(`APM_CMD_SET_MULT);
      rd(4'h9, d);
      chk(d[2], n >= 1 && n <= `APM_MULT_MAX);
      if (n >= 1 && n <= `APM_MULT_MAX)
        chk(d[15:8], n[7:0]);
      rd(4'h1, d);
      chk(d[2], n > `APM_MULT_MAX);
      rd(4'h7, d);
    end
    cmd(`APM_CMD_WR_MULT);
    rd(4'h1, d);
    chk(d[2], 1);
    wr(4'h2, 16'h0002);
    cmd(`APM_CMD_SET_MULT);
    cmd(`APM_CMD_WR_MULT);
    rd(4'h1, d);
    chk(d[2], 0);
    sreset;
    rd(4'h9, d);
    chk(d[2], 0);
    wr(4'h8, 16'h0002);
    cmd(`APM_CMD_SET_MULT);
    sreset;
    rd(4'h9, d);
    chk(d[2], 1);
    wr(4'h8, 16'h0000);
    for (k = 0; k < 6; k = k + 1)
    begin
      wr(4'h2, 16'h00A5);
      cmd(SLP[k*8 +: 8]);
      chk(o_sleep, 1);
      chk(o_intrq, 1);
      rd(4'h7, d);
      chk(o_intrq, 0);
      cmd(`APM_CMD_WEAR);
      chk(o_sleep, 0);
      rd(4'h2, d);
      chk(d, 0);
      rd(4'h7, d);
    end
    repeat (IDLE - 10) @(posedge i_clock);
    #1;
    chk(o_sleep, 0);
    repeat (20) @(posedge i_clock);
    #1;
    chk(o_sleep, 1);
    for (k = 0; k < 2; k = k + 1)
    begin
      sn = 8'($urandom);
      cl = 8'($urandom);
      ch = 8'($urandom);
      dh = {4'hE, 4'($urandom)};
      i_media_erased <= k[0];
      i_media_hot_count <= 24'($urandom);
      wr(4'h3, {8'h00, sn});
      wr(4'h4, {8'h00, cl});
      wr(4'h5, {8'h00, ch});
      wr(4'h6, {8'h00, dh});
      cmd(`APM_CMD_TRANSLATE);
      chk(o_intrq, 1);
      rd(4'h7, d);
      chk(d[7:0], (1 << `APM_ST_DRDY) | (1 << `APM_ST_DRQ));
      for (i = 0; i < 256; i = i + 1)
      begin
        rd(4'h0, d);
        chk(d, {tbyte(2 * i + 1), tbyte(2 * i)});
      end
    end
    cmd(`APM_CMD_WR_BUF);
    chk(o_intrq, 0);
    for (i = 0; i < 256; i = i + 1)
    begin
      d = 16'($urandom);
      wq.push_back(d);
      wr(4'h0, d);
      if (i < 255)
        chk(o_intrq, 0);
    end
    @(posedge i_clock);
    #1;
    chk(o_intrq, 1);
    // the pointer has wrapped, so an idle data read shows buffer word 0
    rd(4'h0, d);
    chk(d, wq[0]);
    rd(4'h7, d);
    wr(4'h8, 16'h0001);
    cmd(`APM_CMD_WR_DMA);
    chk(o_dmareq, 0);
    rd(4'h1, d);
    chk(d[2], 1);
    rd(4'h7, d);
    wr(4'h8, 16'h0000);
    // runs: two sectors across a carry, 256 via count zero, error in sector 1
    for (k = 0; k < 3; k = k + 1)
    begin
      sn = (k == 0) ? 8'hFF : 8'($urandom);
      cl = 8'($urandom);
      ch = 8'($urandom);
      dh = {4'hE, 4'($urandom)};
      n = (k == 1) ? 256 : 2 + k;
      slow <= (k != 1);
      wr(4'h3, {8'h00, sn});
      wr(4'h4, {8'h00, cl});
      wr(4'h5, {8'h00, ch});
      wr(4'h6, {8'h00, dh});
      wr(4'h2, {8'h00, n[7:0]});
      lba = {dh[3:0], ch, cl, sn};
      host_en <= 1'b1;
      base = words;
      cmd(`APM_CMD_WR_DMA);
      chk(o_dmareq, 1);
      i = 0;
      while (o_intrq !== 1'b1 && i < 70000)
      begin
        @(posedge i_clock);
        #1;
        i = i + 1;
        if (k == 2 && words - base == 300 && o_dmareq)
        begin
          i_media_error <= 1'b1;
          @(posedge i_clock);
          i_media_error <= 1'b0;
        end
      end
      host_en <= 1'b0;
      // a loop that ran out of time leaves the interrupt low and counts here
      chk(o_intrq, 1);
      chk(o_dmareq, 0);
      if (k != 2)
        chk(words - base, n * 256);
      lba = lba + ((k == 2) ? 1 : n - 1);
      rd(4'h2, d);
      chk(d[7:0], (k == 2) ? n - 1 : 0);
      rd(4'h3, d);
      chk(d[7:0], lba[7:0]);
      rd(4'h4, d);
      chk(d[7:0], lba[15:8]);
      rd(4'h5, d);
      chk(d[7:0], lba[23:16]);
      rd(4'h6, d);
      chk(d[3:0], lba[27:24]);
      rd(4'h1, d);
      chk(d[6], k == 2);
      rd(4'h7, d);
      chk(d[`APM_ST_ERR], k == 2);
    end
    wr(4'h8, 16'h0004);
    cmd(`APM_CMD_WEAR);
    rd(4'h9, d);
    chk(d[3], 1);
    wrap_up;
  end
endmodule
